//--- cmbp_top.sv
// Purpose: group rate selection and connection memory block fill, AXI4-Lite register slave
// Assumes: frame_pulse_i and memory_fill_allow_i come from logic on core_clk_i
// Notes: one word per cycle is written to each connection memory from the start of a fill until its depth is reached
//
// Operation
// - group 2 rate from bits 7-6
// - group 1 rate from bits 4-3
// - group 0 rate from bits 1-0
// - backplane words get pattern, low bits cleared
// - local words get pattern, low bits cleared
// - start on go rising while allow high
// - fill completes within two frames
// - go bit clears itself on completion unless written 1 in the same cycle
// - clearing go or allow aborts fill
//
// Implementation choice: the AXI4-Lite slave port.
`include "cmbp_defines.svh"
`timescale 1ns/1ps

module cmbp_top
  import cmbp_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int CM_AW = 12,
  parameter int BP_DEPTH = 4096,
  parameter int LC_DEPTH = 2048
)
(
  input wire logic core_clk_i, // 200 MHz clock
  input wire logic sys_rst_i, // async reset, active high
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i, // write address
  input wire logic s_axi_awvalid_i, // write address valid
  output logic s_axi_awready_o, // write address ready
  input wire logic [31:0] s_axi_wdata_i, // write data
  input wire logic [3:0] s_axi_wstrb_i, // write byte strobes
  input wire logic s_axi_wvalid_i, // write data valid
  output logic s_axi_wready_o, // write data ready
  output logic [1:0] s_axi_bresp_o, // write response
  output logic s_axi_bvalid_o, // write response valid
  input wire logic s_axi_bready_i, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr_i, // read address
  input wire logic s_axi_arvalid_i, // read address valid
  output logic s_axi_arready_o, // read address ready
  output logic [31:0] s_axi_rdata_o, // read data
  output logic [1:0] s_axi_rresp_o, // read response
  output logic s_axi_rvalid_o, // read data valid
  input wire logic s_axi_rready_i, // read data ready
  input wire logic memory_fill_allow_i, // fill allow bit of control register
  input wire logic frame_pulse_i, // one-cycle frame boundary
  input wire cmbp_cm_wr_s bp_usr_i, // ordinary backplane memory write
  input wire cmbp_cm_wr_s lc_usr_i, // ordinary local memory write
  output cmbp_cm_wr_s bp_cm_o, // backplane connection memory write port
  output cmbp_cm_wr_s lc_cm_o, // local connection memory write port
  output logic fill_busy_o, // fill in progress, ordinary writes dropped
  output cmbp_rates_s grp_rates_o, // decoded local group rates
  output logic irq_o // level interrupt
);

  localparam int MAX_DEPTH = (BP_DEPTH > LC_DEPTH) ? BP_DEPTH : LC_DEPTH;
  localparam int CNT_W = $clog2(MAX_DEPTH + 1);
  localparam logic [CNT_W-1:0] BP_END = CNT_W'(BP_DEPTH);
  localparam logic [CNT_W-1:0] LC_END = CNT_W'(LC_DEPTH);
  localparam logic [CNT_W-1:0] ALL_END = CNT_W'(MAX_DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic cmbp_rate_e rate_of(input logic [1:0] code);
    unique case (code)
      2'h0: rate_of = CMBP_RATE_8M;
      2'h1: rate_of = CMBP_RATE_4M;
      2'h2: rate_of = CMBP_RATE_2M;
      2'h3: rate_of = CMBP_RATE_RSVD;
    endcase
  endfunction : rate_of

  function automatic logic [15:0] apply_strb(input logic [15:0] old_v, input logic [31:0] wd,
                                             input logic [3:0] strb);
    apply_strb = old_v;
    if (strb[0])
    begin
      apply_strb[7:0] = wd[7:0];
    end
    if (strb[1])
    begin
      apply_strb[15:8] = wd[15:8];
    end
  endfunction : apply_strb

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] idx);
    hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // registers and state

  logic [15:0] mode_reg;
  logic [15:0] fill_reg;
  logic [1:0] stat_reg;
  logic [1:0] mask_reg;
  logic busy;
  logic [CNT_W-1:0] cnt;
  logic [1:0] frames;
  logic [2:0] bp_pat;
  logic [2:0] lc_pat;

  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_do;
  logic wr_mode;
  logic wr_fill;
  logic wr_stat;
  logic wr_mask;
  logic wr_ok;
  logic [15:0] fill_new;
  logic start;
  logic abort;
  logic writes_done;
  logic [1:0] next_frames;
  logic fin;
  logic [1:0] st_set;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel

  assign s_axi_awready_o = ~aw_held & ~s_axi_bvalid_o;
  assign s_axi_wready_o = ~w_held & ~s_axi_bvalid_o;
  assign wr_do = aw_held & w_held & ~s_axi_bvalid_o;
  assign wr_mode = wr_do & hit(aw_addr, `CMBP_IDX_MODE);
  assign wr_fill = wr_do & hit(aw_addr, `CMBP_IDX_FILL);
  assign wr_stat = wr_do & hit(aw_addr, `CMBP_IDX_STAT);
  assign wr_mask = wr_do & hit(aw_addr, `CMBP_IDX_MASK);
  assign wr_ok = wr_mode | wr_fill | wr_stat | wr_mask;

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end
    else if (s_axi_awvalid_i && s_axi_awready_o)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr_i;
    end
    else if (wr_do)
    begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else if (s_axi_wvalid_i && s_axi_wready_o)
    begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata_i;
      w_strb <= s_axi_wstrb_i;
    end
    else if (wr_do)
    begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `CMBP_RESP_OKAY;
    end
    else if (wr_do)
    begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= wr_ok ? `CMBP_RESP_OKAY : `CMBP_RESP_SLVERR;
    end
    else if (s_axi_bready_i)
    begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  assign s_axi_arready_o = ~s_axi_rvalid_o;

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= `CMBP_RESP_OKAY;
    end
    else if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= `CMBP_RESP_OKAY;
      if (hit(s_axi_araddr_i, `CMBP_IDX_MODE))
      begin
        s_axi_rdata_o <= {16'h0000, mode_reg};
      end
      else if (hit(s_axi_araddr_i, `CMBP_IDX_FILL))
      begin
        s_axi_rdata_o <= {16'h0000, fill_reg};
      end
      else if (hit(s_axi_araddr_i, `CMBP_IDX_STAT))
      begin
        s_axi_rdata_o <= {30'h0000_0000, stat_reg};
      end
      else if (hit(s_axi_araddr_i, `CMBP_IDX_MASK))
      begin
        s_axi_rdata_o <= {30'h0000_0000, mask_reg};
      end
      else
      begin
        s_axi_rdata_o <= 32'h0000_0000;
        s_axi_rresp_o <= `CMBP_RESP_SLVERR;
      end
    end
    else if (s_axi_rready_i)
    begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode selection register and decoded group rates

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      mode_reg <= `CMBP_MODE_RST;
    end
    else if (wr_mode)
    begin
      // reserved bits are not stored and read as zero
      mode_reg <= apply_strb(mode_reg, w_data, w_strb) & `CMBP_MODE_WMASK;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      grp_rates_o <= {CMBP_RATE_8M, CMBP_RATE_8M, CMBP_RATE_8M};
    end
    else
    begin
      grp_rates_o.grp2_rate_sel <= rate_of(mode_reg[`CMBP_G2_LSB +: 2]);
      grp_rates_o.grp1_rate_sel <= rate_of(mode_reg[`CMBP_G1_LSB +: 2]);
      grp_rates_o.grp0_rate_sel <= rate_of(mode_reg[`CMBP_G0_LSB +: 2]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // block fill control register

  assign fill_new = apply_strb(fill_reg, w_data, w_strb) & `CMBP_FILL_WMASK;
  assign start = wr_fill & fill_new[`CMBP_GO_BIT] & ~fill_reg[`CMBP_GO_BIT] & memory_fill_allow_i;
  assign abort = busy & ((wr_fill & ~fill_new[`CMBP_GO_BIT]) | ~memory_fill_allow_i);
  assign writes_done = (cnt == ALL_END);
  assign next_frames = (frame_pulse_i && frames != `CMBP_FILL_FRAMES) ? frames + 2'h1 : frames;
  assign fin = busy & ~abort & writes_done & (next_frames == `CMBP_FILL_FRAMES);

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      fill_reg <= `CMBP_FILL_RST;
    end
    else if (wr_fill)
    begin
      fill_reg <= fill_new;
      // go only sticks when the rising write really starts a fill
      fill_reg[`CMBP_GO_BIT] <= (fill_reg[`CMBP_GO_BIT] & fill_new[`CMBP_GO_BIT] & busy) | start;
    end
    else if (fin || abort)
    begin
      fill_reg[`CMBP_GO_BIT] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fill engine

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      busy <= 1'b0;
      cnt <= '0;
      frames <= 2'h0;
      bp_pat <= 3'h0;
      lc_pat <= 3'h0;
    end
    else if (start)
    begin
      busy <= 1'b1;
      cnt <= '0;
      frames <= 2'h0;
      // patterns come from the same write that raised go
      bp_pat <= fill_new[`CMBP_BPAT_LSB +: 3];
      lc_pat <= fill_new[`CMBP_LPAT_LSB +: 3];
    end
    else if (abort || fin)
    begin
      busy <= 1'b0;
    end
    else if (busy)
    begin
      frames <= next_frames;
      if (!writes_done)
      begin
        cnt <= cnt + CNT_W'(1);
      end
    end
  end

  assign fill_busy_o = busy;

  ////////////////////////////////////////////////////////////////////////////
  // connection memory write ports, fill has priority

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      bp_cm_o <= '0;
      lc_cm_o <= '0;
    end
    else
    begin
      if (busy && !abort && cnt < BP_END)
      begin
        bp_cm_o.we <= 1'b1;
        bp_cm_o.addr <= 12'(cnt);
        bp_cm_o.data <= {bp_pat, 13'h0000};
      end
      else if (busy)
      begin
        bp_cm_o <= '0;
      end
      else
      begin
        bp_cm_o <= bp_usr_i;
      end
      if (busy && !abort && cnt < LC_END)
      begin
        lc_cm_o.we <= 1'b1;
        lc_cm_o.addr <= 12'(cnt);
        lc_cm_o.data <= {lc_pat, 13'h0000};
      end
      else if (busy)
      begin
        lc_cm_o <= '0;
      end
      else
      begin
        lc_cm_o <= lc_usr_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status and mask

  always_comb
  begin
    st_set = 2'h0;
    st_set[`CMBP_ST_DONE] = fin;
    st_set[`CMBP_ST_ABORT] = abort;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      stat_reg <= `CMBP_ST_RST;
    end
    else
    begin
      // a new event wins over a same-cycle clear
      stat_reg <= (stat_reg & ~(wr_stat && w_strb[0] ? w_data[1:0] : 2'h0)) | st_set;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      mask_reg <= `CMBP_ST_RST;
    end
    else if (wr_mask && w_strb[0])
    begin
      mask_reg <= w_data[1:0];
    end
  end

  assign irq_o = |(stat_reg & mask_reg);

endmodule : cmbp_top

//--- cmbp_defines.svh
// Purpose: offsets, field positions, reset values and timing counts of the fill block
// Assumes: register indices are word indices, byte address is four times the index
// Notes: included by bare name
`ifndef CMBP_DEFINES_SVH
`define CMBP_DEFINES_SVH

// register word indices
`define CMBP_IDX_MODE 4'h1
`define CMBP_IDX_FILL 4'h2
`define CMBP_IDX_STAT 4'h8
`define CMBP_IDX_MASK 4'h9

// mode selection field positions
`define CMBP_G2_LSB 6
`define CMBP_G1_LSB 3
`define CMBP_G0_LSB 0
`define CMBP_MODE_WMASK 16'h00DB
`define CMBP_MODE_RST 16'h0000

// block fill control field positions
`define CMBP_BPAT_LSB 6
`define CMBP_LPAT_LSB 3
`define CMBP_GO_BIT 2
`define CMBP_FILL_WMASK 16'h01FC
`define CMBP_FILL_RST 16'h0000

// connection memory word layout
`define CMBP_WORD_PAT_LSB 13

// status and mask bits
`define CMBP_ST_DONE 0
`define CMBP_ST_ABORT 1
`define CMBP_ST_RST 2'h0

// frames allowed for one complete fill
`define CMBP_FILL_FRAMES 2'h2

// bus answers
`define CMBP_RESP_OKAY 2'h0
`define CMBP_RESP_SLVERR 2'h2

`endif

//--- cmbp_pkg.sv
// Purpose: types shared by the fill block and its neighbours
// Assumes: connection memories are 16 bits wide with 12-bit addresses at most
// Notes: none
package cmbp_pkg;

  typedef enum logic [1:0] {
    CMBP_RATE_8M,
    CMBP_RATE_4M,
    CMBP_RATE_2M,
    CMBP_RATE_RSVD
  } cmbp_rate_e;

  typedef struct packed {
    cmbp_rate_e grp2_rate_sel;
    cmbp_rate_e grp1_rate_sel;
    cmbp_rate_e grp0_rate_sel;
  } cmbp_rates_s;

  typedef struct packed {
    logic we;
    logic [11:0] addr;
    logic [15:0] data;
  } cmbp_cm_wr_s;

endpackage : cmbp_pkg

//--- cmbp_top_props.sv
// Purpose: port-level properties of the connection memory fill block
// Assumes: frame pulses come further apart than the backplane depth in cycles
// Notes: bound to cmbp_top below the module
`timescale 1ns/1ps

module cmbp_top_props
  import cmbp_pkg::*;
(
  input wire logic core_clk_i, // clock
  input wire logic sys_rst_i, // async reset
  input wire logic s_axi_bvalid_o, // write response valid
  input wire logic memory_fill_allow_i, // fill allow
  input wire logic frame_pulse_i, // frame boundary
  input wire cmbp_cm_wr_s bp_cm_o, // backplane port
  input wire cmbp_cm_wr_s lc_cm_o, // local port
  input wire logic fill_busy_o, // fill running
  input wire cmbp_rates_s grp_rates_o // group rates
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  logic [1:0] fp_cnt;

  ////////////////////////////////////////////////////////////////
  // frame pulses seen since the fill started
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
    if (sys_rst_i)
      fp_cnt <= 2'h0;
    else if (!fill_busy_o)
      fp_cnt <= 2'h0;
    else if (frame_pulse_i && fp_cnt != 2'h3)
      fp_cnt <= fp_cnt + 2'h1;

  ////////////////////////////////////////////////////////////////
  sequence s_fill_run;
    fill_busy_o && $past(fill_busy_o);
  endsequence

  property p_bp_pat;
    s_fill_run ##0 bp_cm_o.we |-> bp_cm_o.data[12:0] == 13'h0000;
  endproperty
  a_bp_pat: assert property (p_bp_pat) else $error("backplane fill word low bits set");

  property p_lc_pat;
    s_fill_run ##0 lc_cm_o.we |-> lc_cm_o.data[12:0] == 13'h0000;
  endproperty
  a_lc_pat: assert property (p_lc_pat) else $error("local fill word low bits set");

  property p_bp_walk;
    s_fill_run ##0 bp_cm_o.we |=> !bp_cm_o.we || bp_cm_o.addr == $past(bp_cm_o.addr) + 12'h001;
  endproperty
  a_bp_walk: assert property (p_bp_walk) else $error("backplane fill address skipped");

  property p_lc_walk;
    s_fill_run ##0 lc_cm_o.we |=> !lc_cm_o.we || lc_cm_o.addr == $past(lc_cm_o.addr) + 12'h001;
  endproperty
  a_lc_walk: assert property (p_lc_walk) else $error("local fill address skipped");

  property p_start;
    $rose(fill_busy_o) |-> $rose(s_axi_bvalid_o) && $past(memory_fill_allow_i);
  endproperty
  a_start: assert property (p_start) else $error("fill started without write and allow");

  property p_abort;
    fill_busy_o && !memory_fill_allow_i |=> !fill_busy_o;
  endproperty
  a_abort: assert property (p_abort) else $error("fill not aborted on allow low");

  property p_frames;
    fill_busy_o |-> fp_cnt < 2'h2;
  endproperty
  a_frames: assert property (p_frames) else $error("fill ran past two frames");

  property p_rates;
    $changed(grp_rates_o) |-> $past(s_axi_bvalid_o) && !$past(s_axi_bvalid_o, 2);
  endproperty
  a_rates: assert property (p_rates) else $error("rates changed without a write");
endmodule : cmbp_top_props

bind cmbp_top cmbp_top_props u_props (.*);

//--- cmbp_top_tb.sv
// Purpose: self-checking bench for the fill block and rate fields
// Assumes: depths shortened to 16 and 8
// Notes: register bus driven as an AXI4-Lite master
`timescale 1ns/1ps

module cmbp_top_tb
  import cmbp_pkg::*;
;
  localparam logic [7:0] A_MODE = 8'h04, A_FILL = 8'h08, A_STAT = 8'h20, A_MASK = 8'h24, A_BAD = 8'h30;
  logic core_clk_i = 1'b0, sys_rst_i = 1'b1, frame_pulse_i = 1'b0, memory_fill_allow_i = 1'b0;
  logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  cmbp_cm_wr_s bp_usr_i = '0, lc_usr_i = '0, bp_cm_o, lc_cm_o;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, fill_busy_o, irq_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  cmbp_rates_s grp_rates_o;
  int failures = 0, n_checks = 0, cycles = 0, bp_n = 0, lc_n = 0;
  logic [2:0] bp_pat = 3'h0, lc_pat = 3'h0;

  cmbp_top #(.BP_DEPTH(16), .LC_DEPTH(8)) uut (.*);

  initial forever #2.5 core_clk_i = ~core_clk_i;

  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  always @(posedge core_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      conclude();
    end
  end

  // fill words seen on the memory ports
  always @(negedge core_clk_i)
    if (fill_busy_o)
    begin
      if (bp_cm_o.we) bp_n++;
      if (lc_cm_o.we) lc_n++;
      if (bp_cm_o.we) chk("bp_word", bp_cm_o.data, {bp_pat, 13'h0});
      if (lc_cm_o.we) chk("lc_word", lc_cm_o.data, {lc_pat, 13'h0});
    end

  ////////////////////////////////////////////////////////////////
  task automatic axi_wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    logic pa, pw, ta, tw, hit;
    logic [1:0] r;
    pa = 1'b1;
    pw = 1'b1;
    hit = 1'b0;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= {16'h0000, d};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    while (pa || pw)
    begin
      #1;
      ta = pa && s_axi_awready_o;
      tw = pw && s_axi_wready_o;
      @(posedge core_clk_i);
      pa = pa && !ta;
      pw = pw && !tw;
      s_axi_awvalid_i <= pa;
      s_axi_wvalid_i <= pw;
    end
    while (!hit)
    begin
      #1;
      hit = s_axi_bvalid_o;
      r = s_axi_bresp_o;
      @(posedge core_clk_i);
    end
    s_axi_bready_i <= 1'b0;
    chk("bresp", r, er);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic hit;
    logic [31:0] d;
    logic [1:0] r;
    hit = 1'b0;
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    while (!hit)
    begin
      #1;
      hit = s_axi_arready_o;
      @(posedge core_clk_i);
    end
    s_axi_arvalid_i <= 1'b0;
    hit = 1'b0;
    while (!hit)
    begin
      #1;
      hit = s_axi_rvalid_o;
      d = s_axi_rdata_o;
      r = s_axi_rresp_o;
      @(posedge core_clk_i);
    end
    s_axi_rready_i <= 1'b0;
    chk("rdata", d, ed);
    chk("rresp", r, er);
  endtask : axi_rd

  ////////////////////////////////////////////////////////////////
  task automatic t_rates();
    for (int c = 0; c < 4; c++)
    begin
      axi_wr(A_MODE, 16'(c * 'h49), 2'h0);
      #1;
      chk("grp2", grp_rates_o.grp2_rate_sel, c);
      chk("grp1", grp_rates_o.grp1_rate_sel, c);
      chk("grp0", grp_rates_o.grp0_rate_sel, c);
      @(posedge core_clk_i);
      axi_rd(A_MODE, 32'(c * 'h49), 2'h0);
    end
  endtask : t_rates

  task automatic t_fill();
    memory_fill_allow_i <= 1'b1;
    axi_wr(A_MASK, 16'h0001, 2'h0);
    bp_pat = 3'h5;
    lc_pat = 3'h3;
    axi_wr(A_FILL, {7'h00, bp_pat, lc_pat, 3'b100}, 2'h0);
    bp_usr_i <= '{1'b1, 12'h003, 16'hFFFF};
    repeat (20) @(posedge core_clk_i);
    frame_pulse_i <= 1'b1;
    @(posedge core_clk_i);
    frame_pulse_i <= 1'b0;
    bp_usr_i <= '0;
    repeat (20) @(posedge core_clk_i);
    chk("busy_mid", fill_busy_o, 1);
    frame_pulse_i <= 1'b1;
    @(posedge core_clk_i);
    frame_pulse_i <= 1'b0;
    #1;
    chk("busy_end", fill_busy_o, 0);
    chk("bp_count", bp_n, 16);
    chk("lc_count", lc_n, 8);
    chk("irq_done", irq_o, 1);
    @(posedge core_clk_i);
    axi_rd(A_FILL, {23'h0, bp_pat, lc_pat, 3'b000}, 2'h0);
    axi_rd(A_STAT, 32'h1, 2'h0);
    axi_wr(A_MASK, 16'h0000, 2'h0);
    chk("irq_masked", irq_o, 0);
    axi_wr(A_MASK, 16'h0001, 2'h0);
    axi_wr(A_STAT, 16'h0001, 2'h0);
    chk("irq_clear", irq_o, 0);
  endtask : t_fill

  task automatic t_abort();
    // 0xB4 carries backplane pattern 2 and local pattern 6
    bp_pat = 3'h2;
    lc_pat = 3'h6;
    axi_wr(A_FILL, 16'h00B4, 2'h0);
    #1;
    chk("busy_run", fill_busy_o, 1);
    @(posedge core_clk_i);
    memory_fill_allow_i <= 1'b0;
    @(posedge core_clk_i);
    #1;
    chk("busy_abort", fill_busy_o, 0);
    @(posedge core_clk_i);
    memory_fill_allow_i <= 1'b1;
    axi_rd(A_FILL, 32'h00B0, 2'h0);
    axi_rd(A_STAT, 32'h2, 2'h0);
    axi_wr(A_FILL, 16'h00B4, 2'h0);
    axi_wr(A_FILL, 16'h00B0, 2'h0);
    chk("busy_go_low", fill_busy_o, 0);
    memory_fill_allow_i <= 1'b0;
    axi_wr(A_FILL, 16'h0074, 2'h0);
    chk("busy_noallow", fill_busy_o, 0);
    axi_rd(A_FILL, 32'h0070, 2'h0);
    axi_wr(A_BAD, 16'h1234, 2'h2);
    axi_rd(A_BAD, 32'h0, 2'h2);
    // idle: ordinary writes reach the memory ports one cycle later
    bp_usr_i <= '{1'b1, 12'h00A, 16'h1234};
    lc_usr_i <= '{1'b1, 12'h005, 16'h4321};
    @(posedge core_clk_i);
    #1;
    chk("bp_pass", bp_cm_o, {1'b1, 12'h00A, 16'h1234});
    chk("lc_pass", lc_cm_o, {1'b1, 12'h005, 16'h4321});
    @(posedge core_clk_i);
    bp_usr_i <= '0;
    lc_usr_i <= '0;
  endtask : t_abort

  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge core_clk_i);
    axi_rd(A_FILL, 32'h0, 2'h0);
    axi_rd(A_MODE, 32'h0, 2'h0);
    t_rates();
    t_fill();
    t_abort();
    conclude();
  end
endmodule : cmbp_top_tb
